// file: hw/mode_pkg.sv
// Purpose: Shared constants and types for the operating-mode state machine
// Assumes: mclk at 40 MHz; serial frames are 32 bits, first bit most significant
// Notes:   Frame layout is [31] write, [30:24] address, [23:8] data, [7:0] checksum
// What this block does
// - Valid frame in Init moves to Normal
// - Checksum ignored for Init to Normal move
// - Sleep request in Init: Normal plus failure flag
// - Invalid content in Init: Normal plus failure flag
// - Normal to Stop only by command, supply good
// - Entering Stop with wake flags raises interrupt
// - Sleep request in Stop: failure flag, Restart
// - Sleep needs supply, cleared flags, wake source
// - Sleep without wake source: failure flag, Restart
// - Reset output low once Sleep accepted
// - Undervoltage or restart-overvoltage at Sleep entry: Restart
// - Thermal or fail-safe overvoltage at Sleep entry: Fail-Safe
// - Stop to Normal only by command, supply good
// - Sleep wakes to Restart on listed events
// - Reset output low throughout Restart
// - Restart entry and wake cause are flagged
// - Restart releases to Normal, watchdog window restarts
// - Fail-Safe to Restart on wake or cooled thermal
// - Leaving Fail-Safe sets its exit flag
// - Peripheral faults only raise an interrupt, unless masked
// - Undervoltage, watchdog or restart-overvoltage faults in Normal/Stop, or bad Sleep, enter Restart
// - Soft reset command returns to Init
// - Four consecutive failures enter Fail-Safe
// - Power-up in Init, wakes there discarded
package mode_pkg;

   typedef enum logic [2:0] {
      MODE_INIT,
      MODE_NORMAL,
      MODE_STOP,
      MODE_SLEEP,
      MODE_RESTART,
      MODE_FAILSAFE
   } mode_t;

   // Mode field values carried in a mode command
   localparam logic [1:0] CMD_NORMAL = 2'h0;
   localparam logic [1:0] CMD_STOP   = 2'h1;
   localparam logic [1:0] CMD_SLEEP  = 2'h2;
   localparam logic [1:0] CMD_SOFT   = 2'h3;

   // Frame field positions
   localparam int FRAME_BITS    = 32;
   localparam int FR_WRITE_BIT  = 31;
   localparam int FR_ADDR_MSB   = 30;
   localparam int FR_ADDR_LSB   = 24;
   localparam int FR_MODE_LSB   = 8;
   localparam int FR_SUM_LSB    = 0;
   localparam logic [6:0] MODE_ADDR     = 7'h01;
   localparam logic [6:0] LAST_REG_ADDR = 7'h3f;

   // Timing
   localparam int CLK_KHZ            = 40000;
   localparam int RESTART_DELAY_US   = 10;
   localparam int RESTART_CYCLES     = (RESTART_DELAY_US * CLK_KHZ + 999) / 1000;
   localparam int INT_PULSE_US       = 100;
   localparam int INT_PULSE_CYCLES   = (INT_PULSE_US * CLK_KHZ + 999) / 1000;
   localparam int THERMAL_DELAY_MS   = 1000;
   localparam int THERMAL_CYCLES_DEF = THERMAL_DELAY_MS * CLK_KHZ;
   localparam int FAIL_LIMIT         = 4;

   // Values after reset
   localparam logic [3:0] WAKE_RESET = 4'h0;
   localparam logic [2:0] CNT_RESET  = 3'h0;

endpackage

// file: hw/frame_if.sv
`timescale 1ns/1ps
// Purpose: Carries a received frame from the link domain to the mode logic
// Assumes: word changes no later than toggle flips
// Notes:   toggle flips once per complete frame
interface frame_if;
   logic [31:0] word;
   logic        toggle;
   modport rx   (output word, output toggle);
   modport core (input word, input toggle);
endinterface

// file: hw/serial_frame_rx.sv
`timescale 1ns/1ps
// Purpose: Shifts in 32-bit serial frames on the link clock
// Assumes: frame select low during a frame; data sampled on rising link clock
// Notes:   The bit counter clears while select is high, so no edge after the frame is needed
module serial_frame_rx (
   // Link pins
   input  wire logic linkClk,
   input  wire logic frameSelN,
   input  wire logic serialIn,
   // Toward the mode logic
   frame_if.rx       lnk
);
   import mode_pkg::*;

   logic [30:0] shift_reg;
   logic [5:0]  bitCnt_reg;
   logic [31:0] word_reg;
   logic        toggle_reg = 1'b0; // Link domain has no reset; the toggle must start known
   wire         lastBit = (bitCnt_reg == 6'(FRAME_BITS - 1));

   // Bit counter; select high clears it, extra bits past 32 are dropped
   always_ff @(posedge linkClk or posedge frameSelN) begin
      if (frameSelN) begin
         bitCnt_reg <= 6'h00;
      end else if (bitCnt_reg != 6'(FRAME_BITS)) begin
         bitCnt_reg <= bitCnt_reg + 6'h01;
      end
   end

   // Shift and publish; word is written before the toggle can be seen
   always_ff @(posedge linkClk) begin
      shift_reg <= {shift_reg[29:0], serialIn};
      if (!frameSelN && lastBit) begin
         word_reg   <= {shift_reg, serialIn};
         toggle_reg <= ~toggle_reg;
      end
   end

   assign lnk.word   = word_reg;
   assign lnk.toggle = toggle_reg;
endmodule

// file: hw/device_mode_state_machine.sv
`timescale 1ns/1ps
// Purpose: Operating-mode state machine: Init, Normal, Stop, Sleep, Restart, Fail-Safe
// Assumes: supply, watchdog, wake and fault inputs are synchronous to mclk
// Notes:   Serial frames arrive on their own link clock and cross by a toggle
module device_mode_state_machine #(
   parameter int THERMAL_CYCLES = mode_pkg::THERMAL_CYCLES_DEF
) (
   // Clock and reset
   input  wire logic          mclk,
   input  wire logic          rst,
   // Serial link
   input  wire logic          linkClk,
   input  wire logic          frameSelN,
   input  wire logic          serialIn,
   // Supply and thermal monitors
   input  wire logic          vsintAbovePor,
   input  wire logic          mainRegAboveReset,
   input  wire logic          regUndervoltage,
   input  wire logic          regOvervoltage,
   input  wire logic          overvoltageReactionSelect,
   input  wire logic          thermalShutdown2,
   // Watchdog
   input  wire logic          wdTriggerFail,
   input  wire logic          wdTriggerOk,
   input  wire logic          wdLongWindowOpen,
   // Wake sources
   input  wire logic          canWake,
   input  wire logic          wakeInput,
   input  wire logic          cyclicSenseWake,
   input  wire logic          cyclicWakeEvent,
   input  wire logic          lsShortBrake,
   input  wire logic          wakeSourceEnabled,
   // Peripheral faults and their interrupt masks
   input  wire logic          canFault,
   input  wire logic          bridgeFault,
   input  wire logic          hsFault,
   input  wire logic [2:0]    faultIntMask,
   // Status clears from the register side
   input  wire logic          statusClear,
   input  wire logic          wakeStatusClear,
   // Pins and status
   output logic               resetOutputN,
   output logic               interruptOutputN,
   output mode_pkg::mode_t    currentMode,
   output logic               spiFailureFlag,
   output logic               restartEntryFlag,
   output logic               failSafeExitFlag,
   output logic [3:0]         wakeStatus,
   output logic               dsOvBrakeFlag,
   // Controls to neighbouring blocks
   output logic               wdLongWindowStart,
   output logic               wdPeriodDefault,
   output logic               softResetLoad,
   output logic               mainRegEnable
);
   import mode_pkg::*;

   frame_if lnk ();

   serial_frame_rx u_rx (
      .linkClk   (linkClk),
      .frameSelN (frameSelN),
      .serialIn  (serialIn),
      .lnk       (lnk)
   );

   mode_t       mode_reg;
   mode_t       modeNext;
   logic        tog1_reg;
   logic        tog2_reg;
   logic        tog3_reg;
   logic        togSeen_reg;
   logic [31:0] frame_reg;
   logic        frameEvt_reg;
   logic        uvPrev_reg;
   logic [2:0]  wdFailCnt_reg;
   logic [2:0]  uvCnt_reg;
   logic [25:0] dlyCnt_reg;
   logic [11:0] intCnt_reg;
   logic [11:0] intCntNext;
   logic        fsByThermal_reg;
   logic        spiFailSet;
   logic        softRst;

   // Toggle crossing: three stages, a change counts once stages two and three agree
   always_ff @(posedge mclk) begin
      tog1_reg <= lnk.toggle;
      tog2_reg <= tog1_reg;
      tog3_reg <= tog2_reg;
   end

   wire togChange = (tog2_reg == tog3_reg) && (tog3_reg != togSeen_reg);

   // Word has been stable for several mclk periods by the time the toggle lands
   always_ff @(posedge mclk) begin
      if (rst) begin
         togSeen_reg  <= 1'b0;
         frameEvt_reg <= 1'b0;
         frame_reg    <= 32'h0000_0000;
      end else begin
         togSeen_reg  <= tog3_reg;
         frameEvt_reg <= togChange;
         if (togChange) begin
            frame_reg <= lnk.word;
         end
      end
   end

   // Frame decode
   wire [6:0] frAddr    = frame_reg[FR_ADDR_MSB:FR_ADDR_LSB];
   wire [1:0] frMode    = frame_reg[FR_MODE_LSB +: 2];
   wire [7:0] frSum     = frame_reg[FR_SUM_LSB +: 8];
   wire       sumOk     = (frSum == (frame_reg[31:24] ^ frame_reg[23:16] ^ frame_reg[15:8]));
   wire       badContent = (frAddr > LAST_REG_ADDR);
   wire       modeWrite = frame_reg[FR_WRITE_BIT] && (frAddr == MODE_ADDR) && !badContent;
   wire       goodFrame = frameEvt_reg && sumOk && !badContent;
   wire       cmdEvt    = frameEvt_reg && sumOk && modeWrite;
   wire       sleepReq  = modeWrite && (frMode == CMD_SLEEP);

   // Fault decode; failure counts reach the limit on the fourth event
   wire uvRise     = regUndervoltage && !uvPrev_reg;
   wire wdLast     = wdTriggerFail && (wdFailCnt_reg == 3'(FAIL_LIMIT - 1));
   wire uvLast     = uvRise && (uvCnt_reg == 3'(FAIL_LIMIT - 1));
   wire ovRestart  = regOvervoltage && !overvoltageReactionSelect;
   wire ovFailSafe = regOvervoltage && overvoltageReactionSelect;
   wire goFailSafe = thermalShutdown2 || ovFailSafe || wdLast || uvLast;
   wire goRestart  = regUndervoltage || wdTriggerFail || ovRestart;

   // Wake decode; ignored in Init so nothing is latched there
   wire       wakeLive  = (mode_reg != MODE_INIT);
   wire [3:0] wakeHits  = {cyclicWakeEvent, cyclicSenseWake, wakeInput, canWake};
   wire       flagsAny  = (|wakeStatus) || dsOvBrakeFlag;
   wire       sleepWake = (|wakeHits) || lsShortBrake || flagsAny;
   wire       fsWake    = canWake || wakeInput || lsShortBrake;
   wire       dlyDone   = (dlyCnt_reg == 26'h0000000);
   wire       tsdDone   = fsByThermal_reg && !thermalShutdown2 && dlyDone;
   wire       initGo    = vsintAbovePor && resetOutputN && wdLongWindowOpen && frameEvt_reg;

   // Next mode; faults are tested before commands
   always_comb begin
      modeNext   = mode_reg;
      spiFailSet = 1'b0;
      softRst    = 1'b0;
      unique case (mode_reg)
         MODE_INIT: begin
            if (initGo) begin
               modeNext   = MODE_NORMAL;
               spiFailSet = sleepReq || badContent;
            end
         end
         MODE_NORMAL, MODE_STOP: begin
            if (goFailSafe) begin
               modeNext = MODE_FAILSAFE;
            end else if (goRestart) begin
               modeNext = MODE_RESTART;
            end else if (frameEvt_reg && (!sumOk || badContent)) begin
               spiFailSet = 1'b1;
            end else if (cmdEvt) begin
               unique case (frMode)
                  CMD_STOP: begin
                     if (mode_reg == MODE_NORMAL && mainRegAboveReset) begin
                        modeNext = MODE_STOP;
                     end
                  end
                  CMD_NORMAL: begin
                     if (mainRegAboveReset) begin
                        modeNext = MODE_NORMAL;
                     end
                  end
                  CMD_SLEEP: begin
                     if (mode_reg == MODE_STOP || !wakeSourceEnabled) begin
                        modeNext   = MODE_RESTART;
                        spiFailSet = 1'b1;
                     end else if (mainRegAboveReset) begin
                        modeNext = MODE_SLEEP;
                     end
                  end
                  CMD_SOFT: begin
                     modeNext = MODE_INIT;
                     softRst  = 1'b1;
                  end
               endcase
            end
         end
         MODE_SLEEP: begin
            if (sleepWake) begin
               modeNext = MODE_RESTART;
            end
         end
         MODE_RESTART: begin
            if (dlyDone && mainRegAboveReset && !regUndervoltage) begin
               modeNext = MODE_NORMAL;
            end
         end
         MODE_FAILSAFE: begin
            if (fsWake || tsdDone) begin
               modeNext = MODE_RESTART;
            end
         end
         default: modeNext = MODE_INIT;
      endcase
   end

   wire enterRestart  = (modeNext == MODE_RESTART) && (mode_reg != MODE_RESTART);
   wire enterFailSafe = (modeNext == MODE_FAILSAFE) && (mode_reg != MODE_FAILSAFE);
   wire leaveFailSafe = (mode_reg == MODE_FAILSAFE) && (modeNext != MODE_FAILSAFE);
   wire enterStop     = (modeNext == MODE_STOP) && (mode_reg != MODE_STOP);

   // One encoded mode register
   always_ff @(posedge mclk) begin
      if (rst) begin
         mode_reg <= MODE_INIT;
      end else begin
         mode_reg <= modeNext;
      end
   end

   // Shared delay timer: reset hold in Restart, cool-down in Fail-Safe
   always_ff @(posedge mclk) begin
      if (rst) begin
         dlyCnt_reg <= 26'h0000000;
      end else if (enterRestart) begin
         dlyCnt_reg <= 26'(RESTART_CYCLES);
      end else if (enterFailSafe || (mode_reg == MODE_FAILSAFE && thermalShutdown2)) begin
         dlyCnt_reg <= 26'(THERMAL_CYCLES);
      end else if (!dlyDone) begin
         dlyCnt_reg <= dlyCnt_reg - 26'h0000001;
      end
   end

   // Thermal cause for Fail-Safe; only it may leave on the cool-down alone
   always_ff @(posedge mclk) begin
      if (rst) begin
         fsByThermal_reg <= 1'b0;
      end else if (enterFailSafe) begin
         fsByThermal_reg <= thermalShutdown2;
      end
   end

   // Consecutive failure counters; a good trigger breaks the watchdog run, a good frame in Normal breaks the undervoltage run
   always_ff @(posedge mclk) begin
      if (rst) begin
         uvPrev_reg    <= 1'b0;
         wdFailCnt_reg <= CNT_RESET;
         uvCnt_reg     <= CNT_RESET;
      end else begin
         uvPrev_reg <= regUndervoltage;
         if (wdTriggerOk || enterFailSafe) begin
            wdFailCnt_reg <= CNT_RESET;
         end else if (wdTriggerFail) begin
            wdFailCnt_reg <= wdFailCnt_reg + 3'h1;
         end
         if ((goodFrame && mode_reg == MODE_NORMAL) || enterFailSafe) begin
            uvCnt_reg <= CNT_RESET;
         end else if (uvRise) begin
            uvCnt_reg <= uvCnt_reg + 3'h1;
         end
      end
   end

   // Status flags; a set in the same cycle as a clear wins
   always_ff @(posedge mclk) begin
      if (rst) begin
         spiFailureFlag   <= 1'b0;
         restartEntryFlag <= 1'b0;
         failSafeExitFlag <= 1'b0;
      end else begin
         spiFailureFlag   <= spiFailSet || (spiFailureFlag && !statusClear && !softRst);
         restartEntryFlag <= enterRestart || (restartEntryFlag && !statusClear);
         failSafeExitFlag <= leaveFailSafe || (failSafeExitFlag && !statusClear);
      end
   end

   // Wake cause flags; Fail-Safe entry wipes them, later events still land
   always_ff @(posedge mclk) begin
      if (rst) begin
         wakeStatus    <= WAKE_RESET;
         dsOvBrakeFlag <= 1'b0;
      end else if (enterFailSafe) begin
         wakeStatus    <= WAKE_RESET;
         dsOvBrakeFlag <= 1'b0;
      end else if (wakeLive) begin
         wakeStatus    <= wakeHits | (wakeStatus & {4{!wakeStatusClear}});
         dsOvBrakeFlag <= lsShortBrake || (dsOvBrakeFlag && !wakeStatusClear);
      end
   end

   // Interrupt events: Stop entry with flags, wakes in Normal or Stop, unmasked peripheral faults
   wire peripheralIrq = |({hsFault, bridgeFault, canFault} & ~faultIntMask);
   wire wakeIrq       = (mode_reg == MODE_NORMAL || mode_reg == MODE_STOP) && (|wakeHits);
   wire stopIrq       = enterStop && flagsAny;
   wire irqEvt        = peripheralIrq || wakeIrq || stopIrq;

   // A fixed-width low pulse; a new event restarts it rather than queueing
   always_comb begin
      if (irqEvt) begin
         intCntNext = 12'(INT_PULSE_CYCLES);
      end else if (intCnt_reg != 12'h000) begin
         intCntNext = intCnt_reg - 12'h001;
      end else begin
         intCntNext = 12'h000;
      end
   end

   // Pin and control outputs; reset, regulator enable and release strobes taken from the coming mode
   wire rstHigh = (modeNext == MODE_NORMAL) || (modeNext == MODE_STOP) ||
                  ((modeNext == MODE_INIT) && mainRegAboveReset);
   wire regOn   = (modeNext != MODE_SLEEP) && (modeNext != MODE_FAILSAFE);
   wire relEdge = (mode_reg == MODE_RESTART) && (modeNext == MODE_NORMAL);

   always_ff @(posedge mclk) begin
      if (rst) begin
         intCnt_reg        <= 12'h000;
         interruptOutputN  <= 1'b1;
         resetOutputN      <= 1'b0;
         mainRegEnable     <= 1'b1;
         wdLongWindowStart <= 1'b0;
         wdPeriodDefault   <= 1'b0;
         softResetLoad     <= 1'b0;
      end else begin
         intCnt_reg        <= intCntNext;
         interruptOutputN  <= (intCntNext == 12'h000);
         resetOutputN      <= rstHigh;
         mainRegEnable     <= regOn;
         wdLongWindowStart <= relEdge;
         wdPeriodDefault   <= relEdge;
         softResetLoad     <= softRst;
      end
   end

   assign currentMode = mode_reg;
endmodule

// file: verif/host_frame_model.sv
// Purpose: Host side of the serial link, sending whole 32-bit frames
// Assumes: data is sampled by the device on the rising link clock
// Notes:   Link clock stands still between frames; idle data is the inverse of the last bit
`timescale 1ns/1ps
module host_frame_model (
   // Link pins
   output logic linkClk,
   output logic frameSelN,
   output logic serialIn
);
   // Idle link from time zero
   initial begin
      linkClk = 1'b0;
      frameSelN = 1'b1;
      serialIn = 1'b1;
   end
   // 160 ns bits; data moves while the clock is low so it never races the sampling edge
   task automatic send(input logic [31:0] w);
      #37 frameSelN = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         serialIn = w[i];
         #80 linkClk = 1'b1;
         #80 linkClk = 1'b0;
      end
      #80 frameSelN = 1'b1;
      serialIn = ~w[0]; // A released line must not look like held data
   endtask
endmodule

// file: verif/device_mode_state_machine_props.sv
// Purpose: Port-level checks for the mode state machine
// Assumes: one mclk domain with synchronous rst
// Notes:   Faults may win over one another, so Restart checks accept Fail-Safe too
`timescale 1ns/1ps
module device_mode_state_machine_props (
   // Clock, reset and events
   input wire logic       mclk,
   input wire logic       rst,
   input wire logic       regUndervoltage,
   input wire logic       regOvervoltage,
   input wire logic       overvoltageReactionSelect,
   input wire logic       thermalShutdown2,
   input wire logic       canWake,
   input wire logic       wakeInput,
   input wire logic       cyclicSenseWake,
   input wire logic       cyclicWakeEvent,
   input wire logic       lsShortBrake,
   input wire logic       canFault,
   input wire logic [2:0] faultIntMask,
   // Design outputs
   input wire logic       resetOutputN,
   input wire logic       interruptOutputN,
   input mode_pkg::mode_t currentMode,
   input wire logic       restartEntryFlag,
   input wire logic       failSafeExitFlag,
   input wire logic [3:0] wakeStatus,
   input wire logic       wdLongWindowStart,
   input wire logic       wdPeriodDefault
);
   import mode_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // Summary terms
   wire run = currentMode inside {MODE_NORMAL, MODE_STOP};
   wire wake = canWake | wakeInput | cyclicSenseWake | cyclicWakeEvent | lsShortBrake;
   wire inRestart = currentMode == MODE_RESTART;
   property p_rstRestart; inRestart |-> !resetOutputN; endproperty
   a_rstRestart: assert property (p_rstRestart) else $error("reset high in restart");
   property p_rstSleep; currentMode == MODE_SLEEP |-> !resetOutputN; endproperty
   a_rstSleep: assert property (p_rstSleep) else $error("reset high in sleep");
   property p_toRestart;
      run && (regUndervoltage || regOvervoltage && !overvoltageReactionSelect)
      |=> currentMode inside {MODE_RESTART, MODE_FAILSAFE};
   endproperty
   a_toRestart: assert property (p_toRestart) else $error("fault kept mode");
   property p_toFail;
      run && (thermalShutdown2 || regOvervoltage && overvoltageReactionSelect)
      |=> currentMode == MODE_FAILSAFE;
   endproperty
   a_toFail: assert property (p_toFail) else $error("no fail-safe on fault");
   property p_sleepWake; currentMode == MODE_SLEEP && wake |=> inRestart; endproperty
   a_sleepWake: assert property (p_sleepWake) else $error("sleep wake lost");
   property p_rstFlag; $rose(inRestart) |-> restartEntryFlag; endproperty
   a_rstFlag: assert property (p_rstFlag) else $error("restart entry unflagged");
   property p_fsExit;
      !$past(rst) && $past(currentMode) == MODE_FAILSAFE && currentMode != MODE_FAILSAFE
      |-> failSafeExitFlag;
   endproperty
   a_fsExit: assert property (p_fsExit) else $error("fail-safe exit unflagged");
   property p_release;
      $past(inRestart) && currentMode == MODE_NORMAL
      |-> resetOutputN && wdLongWindowStart && wdPeriodDefault;
   endproperty
   a_release: assert property (p_release) else $error("restart release wrong");
   property p_faultInt; canFault && !faultIntMask[0] |=> !interruptOutputN; endproperty
   a_faultInt: assert property (p_faultInt) else $error("fault interrupt missing");
   property p_stopInt;
      $rose(currentMode == MODE_STOP) && wakeStatus != 4'h0 |-> ##[0:1] !interruptOutputN;
   endproperty
   a_stopInt: assert property (p_stopInt) else $error("stop interrupt missing");
   // Main scenarios reached
   c_sleepWake: cover property (currentMode == MODE_SLEEP && wake);
   c_fsExit: cover property ($rose(failSafeExitFlag));
   c_stopInt: cover property ($rose(currentMode == MODE_STOP) && wakeStatus != 4'h0);
endmodule
bind device_mode_state_machine device_mode_state_machine_props u_props (.*);

// file: verif/test_device_mode_state_machine.sv
// Purpose: Self-checking bench for the operating-mode state machine
// Assumes: supply good and watchdog window open unless a case drives a fault
// Notes:   Thermal release delay shortened to 20 cycles to keep the run short
`timescale 1ns/1ps
module test_device_mode_state_machine;
   import mode_pkg::*;
   localparam int THERM = 20;
   localparam int LIMIT = 60000;
   // Bench drives
   logic        mclk = 1'b0, rst = 1'b1;
   logic        vsintAbovePor = 1'b1, mainRegAboveReset = 1'b1, wdLongWindowOpen = 1'b1;
   logic        regUndervoltage = 1'b0, regOvervoltage = 1'b0, thermalShutdown2 = 1'b0;
   logic        overvoltageReactionSelect = 1'b0, wakeSourceEnabled = 1'b1;
   logic [2:0]  faultIntMask = 3'h7;
   logic [11:0] ev = 12'h000;
   logic [31:0] seed = 32'h0000003b;
   int          mismatches, checked, cyc;
   // Design pins
   wire         linkClk, frameSelN, serialIn, canWake, wakeInput, cyclicSenseWake;
   wire         cyclicWakeEvent, lsShortBrake, wdTriggerFail, wdTriggerOk, statusClear;
   wire         wakeStatusClear, canFault, bridgeFault, hsFault, resetOutputN;
   wire         interruptOutputN, spiFailureFlag, restartEntryFlag, failSafeExitFlag;
   wire         dsOvBrakeFlag, wdLongWindowStart, wdPeriodDefault, softResetLoad, mainRegEnable;
   wire [3:0]   wakeStatus;
   mode_t       currentMode;
   // Event pulses from one vector
   assign {hsFault, bridgeFault, canFault, wakeStatusClear, statusClear, wdTriggerOk,
      wdTriggerFail, lsShortBrake, cyclicWakeEvent, cyclicSenseWake, wakeInput, canWake} = ev;
   device_mode_state_machine #(.THERMAL_CYCLES(THERM)) u_dut (.*);
   host_frame_model u_host (.*);
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   // Hang guard
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         mismatches++;
         end_sim();
      end
   end
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Write frame to a given place; checksum is the XOR of the three upper bytes, its low bit flipped when g is low
   function automatic logic [31:0] mk(input logic [6:0] a, input logic [1:0] m, input logic g);
      logic [23:0] h;
      h = {1'b1, a, 14'h0000, m};
      return {h, h[23:16] ^ h[15:8] ^ h[7:0] ^ {7'h00, !g}};
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask
   task automatic pulse(input logic [11:0] m);
      ev = m;
      tick(1);
      ev = 12'h000;
   endtask
   // The gap after a frame also keeps frame ends well apart
   task automatic frame(input logic [6:0] a, input logic [1:0] m, input logic g);
      u_host.send(mk(a, m, g));
      tick(10);
   endtask
   task automatic checkBit(input string n, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("CHECK FAILED %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic checkMode(input mode_t e);
      checked++;
      if (currentMode !== e) begin
         mismatches++;
         $display("CHECK FAILED currentMode expected %0d seen %0d", e, currentMode);
      end
   endtask
   task automatic waitMode(input mode_t e);
      for (int n = 0; n < 1000 && currentMode !== e; n++) tick(1);
      checkMode(e);
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      tick(4);
      rst = 1'b0;
      tick(2);
      checkMode(MODE_INIT);
      pulse(12'h001);
      tick(2);
      checkBit("wakeStatus", 1'b0, |wakeStatus);
      // First frame: bad checksum, refused Sleep request
      frame(MODE_ADDR, CMD_SLEEP, 1'b0);
      checkMode(MODE_NORMAL);
      checkBit("spiFail", 1'b1, spiFailureFlag);
      frame(MODE_ADDR, CMD_SOFT, 1'b1);
      checkMode(MODE_INIT);
      checkBit("spiFail", 1'b0, spiFailureFlag);
      frame(7'h7f, CMD_NORMAL, 1'b1);
      checkMode(MODE_NORMAL);
      checkBit("spiFail", 1'b1, spiFailureFlag);
      $display("init test done");
      // Peripheral faults: masked, then with a random mask leaving the bus fault open
      pulse(12'he00);
      tick(2);
      checkBit("interrupt_output_n", 1'b1, interruptOutputN);
      faultIntMask = 3'(rnd()) & 3'h6;
      pulse(12'he00);
      tick(2);
      checkBit("interrupt_output_n", 1'b0, interruptOutputN);
      checkMode(MODE_NORMAL);
      pulse(12'h002);
      for (int n = 0; n < 5000 && interruptOutputN !== 1'b1; n++) tick(1);
      checkBit("interrupt_output_n", 1'b1, interruptOutputN);
      frame(7'h02, CMD_STOP, 1'b1);
      checkMode(MODE_NORMAL);
      frame(MODE_ADDR, CMD_STOP, 1'b1);
      checkMode(MODE_STOP);
      checkBit("interrupt_output_n", 1'b0, interruptOutputN);
      frame(MODE_ADDR, CMD_NORMAL, 1'b1);
      checkMode(MODE_NORMAL);
      frame(MODE_ADDR, CMD_STOP, 1'b1);
      pulse(12'h080);
      frame(MODE_ADDR, CMD_SLEEP, 1'b1);
      checkMode(MODE_RESTART);
      checkBit("spiFail", 1'b1, spiFailureFlag);
      checkBit("reset_output_n", 1'b0, resetOutputN);
      waitMode(MODE_NORMAL);
      checkBit("rstFlag", 1'b1, restartEntryFlag);
      checkBit("reset_output_n", 1'b1, resetOutputN);
      wakeSourceEnabled = 1'b0;
      frame(MODE_ADDR, CMD_SLEEP, 1'b1);
      checkMode(MODE_RESTART);
      wakeSourceEnabled = 1'b1;
      waitMode(MODE_NORMAL);
      $display("stop test done");
      // Every wake source from Sleep, after a random delay
      for (int i = 0; i < 5; i++) begin
         pulse(12'h100);
         frame(MODE_ADDR, CMD_SLEEP, 1'b1);
         checkMode(MODE_SLEEP);
         checkBit("reset_output_n", 1'b0, resetOutputN);
         checkBit("regEn", 1'b0, mainRegEnable);
         tick(rnd() % 40);
         pulse(12'h001 << i);
         tick(1);
         checkMode(MODE_RESTART);
         checkBit("wake", 1'b1, i < 4 ? wakeStatus[i] : dsOvBrakeFlag);
         waitMode(MODE_NORMAL);
      end
      // Undervoltage, overvoltage both ways, thermal
      for (int k = 0; k < 4; k++) begin
         pulse(12'h080);
         overvoltageReactionSelect = (k == 2);
         {thermalShutdown2, regOvervoltage, regUndervoltage} = {k == 3, k == 1 || k == 2, k == 0};
         tick(1);
         {thermalShutdown2, regOvervoltage, regUndervoltage} = 3'h0;
         tick(1);
         checkMode(k < 2 ? MODE_RESTART : MODE_FAILSAFE);
         if (k == 2) pulse(12'h001);
         if (k >= 2) waitMode(MODE_RESTART);
         if (k >= 2) checkBit("fsExit", 1'b1, failSafeExitFlag);
         waitMode(MODE_NORMAL);
      end
      pulse(12'h040);
      for (int j = 0; j < 4; j++) begin
         pulse(12'h020);
         tick(1);
         checkMode(j < 3 ? MODE_RESTART : MODE_FAILSAFE);
         if (j < 3) waitMode(MODE_NORMAL);
      end
      pulse(12'h002);
      waitMode(MODE_RESTART);
      $display("fault test done");
      end_sim();
   end
endmodule
